// ==== verilog/debug_control_access_port.v ====
// control access port behind a minimal two-wire serial debug port
// Function
// - control port works regardless of port protection
// - soft reset bit holds device in reset
// - writing one to erase starts full erase
// - erase status reads one while erase busy
// - protection status reads zero while protected
// - identification word with revision, maker, class, id
// - protection status follows the port_protection input; erase does not change it
`include "debug_control_access_port_defs.vh"

module debug_control_access_port (
  input wire clk_sys,
  input wire reset,
  input wire swdclk,
  input wire swdio_in,
  output reg swdio_out,
  output reg swdio_oe,
  input wire port_protection,
  input wire erase_done,
  output reg soft_reset,
  output reg erase_start,
  output reg erase_busy,
  output reg power_up_request
);

  // =====================================================
  // link states
  localparam ST_REQ = 3'd0;
  localparam ST_TRN1 = 3'd1;
  localparam ST_ACK = 3'd2;
  localparam ST_RDATA = 3'd3;
  localparam ST_TRNR = 3'd4;
  localparam ST_TRNW = 3'd5;
  localparam ST_WDATA = 3'd6;

  wire rise;
  wire io;
  reg [2:0] state_reg;
  reg [5:0] cnt_reg;
  reg [5:0] ones_reg;
  reg [6:0] req_sh_reg;
  reg [32:0] wsh_reg;
  reg ap_reg;
  reg rnw_reg;
  reg [1:0] addr_reg;
  reg [2:0] ack_reg;
  reg [31:0] rdata_reg;
  reg [31:0] rdbuf_reg;
  reg [7:0] apsel_reg;
  reg [3:0] bank_reg;
  reg [1:0] pwr_reg;

  // =====================================================
  // pin synchronisers
  swd_pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .swdclk(swdclk),
    .swdio_in(swdio_in),
    .clk_rise(rise),
    .io_level(io)
  );

  // =====================================================
  // request decode
  wire [7:0] req_full = {io, req_sh_reg};
  wire req_valid = (req_full[5] == ^req_full[4:1]) && !req_full[6] && req_full[7];
  wire [7:0] ap_offset = {bank_reg, addr_reg, 2'b00};
  wire ours = (apsel_reg == `CAP_PORT_SELECT) && power_up_request;
  wire [32:0] wfull = {io, wsh_reg[32:1]};
  wire wpar_ok = (wfull[32] == ^wfull[31:0]);

  // =====================================================
  // register read values
  reg [31:0] ap_value;
  reg [31:0] dp_value;
  always @* begin
    ap_value = 32'h00000000;
    if (ours) begin
      case (ap_offset)
        `CAP_OFS_SOFT_RESET: ap_value = {31'h00000000, soft_reset};
        `CAP_OFS_ERASE_STATUS: ap_value = {31'h00000000, erase_busy};
        `CAP_OFS_PROTECT_STATUS: ap_value = {31'h00000000, ~port_protection};
        `CAP_OFS_IDENT: ap_value = {`IDENT_REVISION, `IDENT_MAKER_BANK, `IDENT_MAKER_CODE,
                                    `IDENT_CLASS_NONE, 5'h00, `IDENT_PORT_ID};
        default: ap_value = 32'h00000000;
      endcase
    end
    case (addr_reg)
      `DP_ADDR_IDENT: dp_value = `DP_IDENT_WORD;
      `DP_ADDR_CTRL: dp_value = {pwr_reg[1], pwr_reg[1], pwr_reg[0], pwr_reg[0], 28'h0000000};
      `DP_ADDR_RDBUF: dp_value = rdbuf_reg;
      default: dp_value = 32'h00000000;
    endcase
  end

  // =====================================================
  // serial engine and registers
  always @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= ST_REQ;
      cnt_reg <= 6'd0;
      ones_reg <= 6'd0;
      req_sh_reg <= 7'h00;
      wsh_reg <= 33'h000000000;
      ap_reg <= 1'b0;
      rnw_reg <= 1'b0;
      addr_reg <= 2'b00;
      ack_reg <= `ACK_OK;
      rdata_reg <= 32'h00000000;
      rdbuf_reg <= 32'h00000000;
      apsel_reg <= 8'h00;
      bank_reg <= 4'h0;
      pwr_reg <= 2'b00;
      swdio_out <= 1'b0;
      swdio_oe <= 1'b0;
      soft_reset <= 1'b0;
      erase_start <= 1'b0;
      erase_busy <= 1'b0;
      power_up_request <= 1'b0;
    end else begin
      erase_start <= 1'b0;
      power_up_request <= pwr_reg[0] | pwr_reg[1];
      if (erase_done && !erase_start) begin
        erase_busy <= 1'b0;
      end
      if (rise) begin
        if (!swdio_oe) begin
          ones_reg <= io ? ((ones_reg == `LINE_RESET_ONES) ? ones_reg : ones_reg + 6'd1) : 6'd0;
        end
        if (!swdio_oe && io && ones_reg == `LINE_RESET_ONES - 6'd1) begin
          state_reg <= ST_REQ;
          cnt_reg <= 6'd0;
        end else begin
          case (state_reg)
            ST_REQ: begin
              if (cnt_reg == 6'd0 && !io) begin
                cnt_reg <= 6'd0;
              end else if (cnt_reg == `REQ_BITS - 6'd1) begin
                cnt_reg <= 6'd0;
                if (req_valid) begin
                  ap_reg <= req_full[1];
                  rnw_reg <= req_full[2];
                  addr_reg <= req_full[4:3];
                  state_reg <= ST_TRN1;
                end
              end else begin
                req_sh_reg <= {io, req_sh_reg[6:1]};
                cnt_reg <= cnt_reg + 6'd1;
              end
            end
            ST_TRN1: begin
              if (ap_reg && !ours && !(apsel_reg == `CAP_PORT_SELECT)) begin
                ack_reg <= `ACK_OK;
                swdio_out <= 1'b1;
              end else if (ap_reg && !power_up_request) begin
                ack_reg <= `ACK_FAULT;
                swdio_out <= 1'b0;
              end else begin
                ack_reg <= `ACK_OK;
                swdio_out <= 1'b1;
              end
              swdio_oe <= 1'b1;
              rdata_reg <= ap_reg ? rdbuf_reg : dp_value;
              if (ap_reg && rnw_reg) begin
                rdbuf_reg <= ap_value;
              end
              cnt_reg <= 6'd1;
              state_reg <= ST_ACK;
            end
            ST_ACK: begin
              if (cnt_reg < 6'd3) begin
                swdio_out <= ack_reg[cnt_reg[1:0]];
                cnt_reg <= cnt_reg + 6'd1;
              end else if (ack_reg == `ACK_OK && rnw_reg) begin
                swdio_out <= rdata_reg[0];
                cnt_reg <= 6'd1;
                state_reg <= ST_RDATA;
              end else begin
                swdio_oe <= 1'b0;
                cnt_reg <= 6'd0;
                state_reg <= (ack_reg == `ACK_OK) ? ST_TRNW : ST_TRNR;
              end
            end
            ST_RDATA: begin
              if (cnt_reg < `DATA_BITS) begin
                swdio_out <= rdata_reg[cnt_reg[4:0]];
                cnt_reg <= cnt_reg + 6'd1;
              end else if (cnt_reg == `DATA_BITS) begin
                swdio_out <= ^rdata_reg;
                cnt_reg <= cnt_reg + 6'd1;
              end else begin
                swdio_oe <= 1'b0;
                cnt_reg <= 6'd0;
                state_reg <= ST_TRNR;
              end
            end
            ST_TRNR: begin
              state_reg <= ST_REQ;
            end
            ST_TRNW: begin
              cnt_reg <= 6'd0;
              state_reg <= ST_WDATA;
            end
            ST_WDATA: begin
              wsh_reg <= wfull;
              if (cnt_reg == `DATA_BITS) begin
                cnt_reg <= 6'd0;
                state_reg <= ST_REQ;
                if (wpar_ok && !ap_reg) begin
                  if (addr_reg == `DP_ADDR_CTRL) begin
                    pwr_reg <= {wfull[`DP_SYS_PWR_REQ_BIT], wfull[`DP_DBG_PWR_REQ_BIT]};
                  end else if (addr_reg == `DP_ADDR_SELECT) begin
                    apsel_reg <= wfull[31:24];
                    bank_reg <= wfull[7:4];
                  end
                end else if (wpar_ok && ours) begin
                  if (ap_offset == `CAP_OFS_SOFT_RESET) begin
                    soft_reset <= wfull[`CAP_CMD_BIT];
                  end else if (ap_offset == `CAP_OFS_MASS_ERASE && wfull[`CAP_CMD_BIT] && !erase_busy) begin
                    erase_start <= 1'b1;
                    erase_busy <= 1'b1;
                  end
                end
              end else begin
                cnt_reg <= cnt_reg + 6'd1;
              end
            end
            default: begin
              state_reg <= ST_REQ;
            end
          endcase
        end
      end
    end
  end

endmodule // debug_control_access_port

// ==== include/debug_control_access_port_defs.vh ====
// constants for the control access port and its serial link
`ifndef DEBUG_CONTROL_ACCESS_PORT_DEFS_VH
`define DEBUG_CONTROL_ACCESS_PORT_DEFS_VH

// =====================================================
// control access port register offsets
`define CAP_OFS_SOFT_RESET 8'h00
`define CAP_OFS_MASS_ERASE 8'h04
`define CAP_OFS_ERASE_STATUS 8'h08
`define CAP_OFS_PROTECT_STATUS 8'h0C
`define CAP_OFS_IDENT 8'hFC

// =====================================================
// field positions and values
`define CAP_CMD_BIT 0
`define CAP_RESET_VALUE 32'h00000000
`define IDENT_CLASS_NONE 4'h0
`define IDENT_CLASS_MEMORY 4'h8
// arbitrary identity values
`define IDENT_REVISION 4'h1
`define IDENT_MAKER_BANK 4'h0
`define IDENT_MAKER_CODE 7'h00
`define IDENT_PORT_ID 8'h01
`define DP_IDENT_WORD 32'h10000001

// =====================================================
// debug port side
`define CAP_PORT_SELECT 8'h01
`define DP_ADDR_IDENT 2'h0
`define DP_ADDR_CTRL 2'h1
`define DP_ADDR_SELECT 2'h2
`define DP_ADDR_RDBUF 2'h3
`define DP_DBG_PWR_REQ_BIT 28
`define DP_SYS_PWR_REQ_BIT 30
`define ACK_OK 3'b001
`define ACK_FAULT 3'b100

// =====================================================
// link timing counts
`define REQ_BITS 6'd8
`define DATA_BITS 6'd32
`define LINE_RESET_ONES 6'd50

`endif

// ==== verilog/swd_pin_sync.v ====
// two-flop synchronisers for the serial debug pins, with clock edge detect
module swd_pin_sync (
  input wire clk_sys,
  input wire reset,
  input wire swdclk,
  input wire swdio_in,
  output reg clk_rise,
  output reg io_level
);

  reg clk_meta_reg;
  reg clk_sync_reg;
  reg clk_last_reg;
  reg io_meta_reg;

  always @(posedge clk_sys) begin
    if (reset) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_last_reg <= 1'b0;
      io_meta_reg <= 1'b1;
      io_level <= 1'b1;
      clk_rise <= 1'b0;
    end else begin
      clk_meta_reg <= swdclk;
      clk_sync_reg <= clk_meta_reg;
      clk_last_reg <= clk_sync_reg;
      io_meta_reg <= swdio_in;
      io_level <= io_meta_reg;
      clk_rise <= clk_sync_reg & ~clk_last_reg;
    end
  end

endmodule // swd_pin_sync

// ==== dv/debug_control_access_port_sva.sv ====
// pin-level checks for the control access port
module debug_control_access_port_sva (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic swdclk,
  input wire logic swdio_in,
  input wire logic swdio_out,
  input wire logic swdio_oe,
  input wire logic port_protection,
  input wire logic erase_done,
  input wire logic soft_reset,
  input wire logic erase_start,
  input wire logic erase_busy,
  input wire logic power_up_request
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // link edge age
  logic clk_prev;
  logic [3:0] since_edge;
  always_ff @(posedge clk_sys) begin
    clk_prev <= swdclk;
    if (reset) since_edge <= 4'hF;
    else if (swdclk && !clk_prev) since_edge <= 4'h0;
    else if (since_edge != 4'hF) since_edge <= since_edge + 4'h1;
  end
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_busy_soon; ##[0:1] erase_busy; endsequence
  sequence s_done; erase_busy && erase_done; endsequence
  property p_start_busy; erase_start |-> s_busy_soon; endproperty
  property p_start_pulse; erase_start |=> !erase_start; endproperty
  property p_busy_hold; erase_busy && !erase_done |=> erase_busy; endproperty
  property p_busy_end; s_done |=> !erase_busy; endproperty
  property p_start_idle; erase_start |-> !$past(erase_busy); endproperty
  property p_busy_cause; $rose(erase_busy) |-> erase_start || $past(erase_start); endproperty
  property p_reset_link; $changed(soft_reset) |-> since_edge < 4'h8; endproperty
  property p_start_link; erase_start |-> since_edge < 4'h8; endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy late");
  a_start_pulse: assert property (p_start_pulse) else $error("start long");
  a_busy_hold: assert property (p_busy_hold) else $error("busy lost");
  a_busy_end: assert property (p_busy_end) else $error("busy stuck");
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  a_busy_cause: assert property (p_busy_cause) else $error("busy no start");
  a_reset_link: assert property (p_reset_link) else $error("reset no link");
  a_start_link: assert property (p_start_link) else $error("start no link");
endmodule // debug_control_access_port_sva

bind debug_control_access_port debug_control_access_port_sva u_sva (.clk_sys(clk_sys), .reset(reset),
  .swdclk(swdclk), .swdio_in(swdio_in), .swdio_out(swdio_out), .swdio_oe(swdio_oe),
  .port_protection(port_protection), .erase_done(erase_done), .soft_reset(soft_reset),
  .erase_start(erase_start), .erase_busy(erase_busy), .power_up_request(power_up_request));

// ==== dv/debug_probe_model.sv ====
// serial debug probe driving the two-wire link
`include "debug_control_access_port_defs.vh"
module debug_probe_model (
  input wire logic clk_sys,
  output logic swdclk,
  output logic swdio_in,
  input wire logic swdio_out,
  input wire logic swdio_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_oe = 1'b1;
  logic host_val = 1'b0;
  logic flip_par = 1'b0;
  logic par_bad = 1'b0;
  // line pulled up when nobody drives
  assign swdio_in = swdio_oe ? swdio_out : (host_oe ? host_val : 1'b1);
  initial swdclk = 1'b0;
  // ==========
  // one link period, change on fall, sample on rise
  task automatic cyc(input logic drv, input logic b, output logic r);
    host_oe = drv;
    host_val = b;
    #80;
    swdclk = 1'b1;
    r = swdio_in;
    #80;
    swdclk = 1'b0;
  endtask
  task automatic line_reset;
    logic r;
    @(negedge clk_sys);
    repeat (56) cyc(1'b1, 1'b1, r);
    repeat (2) cyc(1'b1, 1'b0, r);
  endtask
  task automatic xfer(input logic ap, input logic rd, input logic [1:0] a, input logic [31:0] wd,
                      output logic [2:0] ack, output logic [31:0] rdat);
    logic [7:0] req;
    logic [33:0] s;
    logic r;
    req = {1'b1, 1'b0, ^{a, rd, ap}, a, rd, ap, 1'b1};
    @(negedge clk_sys);
    for (int i = 0; i < 8; i++) cyc(1'b1, req[i], r);
    for (int i = 0; i < 4; i++) begin
      cyc(1'b0, 1'b0, r);
      s[i] = r;
    end
    ack = s[3:1];
    rdat = 32'h00000000;
    if (ack == `ACK_OK && rd) begin
      for (int i = 0; i < 34; i++) begin
        cyc(1'b0, 1'b0, r);
        s[i] = r;
      end
      rdat = s[31:0];
      if (s[32] != ^s[31:0]) par_bad = 1'b1;
    end else begin
      cyc(1'b0, 1'b0, r);
      if (ack == `ACK_OK) begin
        for (int i = 0; i < 33; i++) cyc(1'b1, i < 32 ? wd[i] : ^{wd, flip_par}, r);
      end
    end
    repeat (2) cyc(1'b1, 1'b0, r);
  endtask
endmodule // debug_probe_model

// ==== dv/testbench.sv ====
// self-checking bench for the control access port
`include "debug_control_access_port_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset, port_protection, erase_done;
  wire swdclk, swdio_in, swdio_out, swdio_oe, soft_reset, erase_start, erase_busy, power_up_request;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int starts = 0;
  logic [2:0] ack;
  logic [31:0] rdat;
  debug_control_access_port uut (.clk_sys(clk_sys), .reset(reset), .swdclk(swdclk), .swdio_in(swdio_in),
    .swdio_out(swdio_out), .swdio_oe(swdio_oe), .port_protection(port_protection), .erase_done(erase_done),
    .soft_reset(soft_reset), .erase_start(erase_start), .erase_busy(erase_busy),
    .power_up_request(power_up_request));
  debug_probe_model probe (.clk_sys(clk_sys), .swdclk(swdclk), .swdio_in(swdio_in), .swdio_out(swdio_out),
    .swdio_oe(swdio_oe));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (erase_start) starts <= starts + 1;
    if (cycles == 40000) begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t timeout", $time);
      stop_test;
    end
  end
  // ==========
  // access tasks
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic sel(input logic [3:0] bank);
    probe.xfer(1'b0, 1'b0, `DP_ADDR_SELECT, {`CAP_PORT_SELECT, 16'h0000, bank, 4'h0}, ack, rdat);
  endtask
  task automatic wr(input logic [7:0] off, input logic [31:0] d);
    sel(off[7:4]);
    probe.xfer(1'b1, 1'b0, off[3:2], d, ack, rdat);
    cmp({29'h0, ack}, {29'h0, `ACK_OK}, "write ack");
  endtask
  task automatic rd(input logic [7:0] off, input logic [31:0] exp, input string what);
    sel(off[7:4]);
    probe.xfer(1'b1, 1'b1, off[3:2], 32'h0, ack, rdat);
    probe.xfer(1'b0, 1'b1, `DP_ADDR_RDBUF, 32'h0, ack, rdat);
    cmp(rdat, exp, what);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    reset = 1'b1;
    port_protection = 1'b1;
    erase_done = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) reset = 1'b0;
    repeat (5) @(negedge clk_sys);
    cmp({27'h0, soft_reset, erase_busy, power_up_request, erase_start, swdio_oe}, 32'h0, "reset outputs");
    probe.line_reset();
    sel(4'h0);
    probe.xfer(1'b1, 1'b1, 2'h3, 32'h0, ack, rdat);
    cmp({29'h0, ack}, {29'h0, `ACK_FAULT}, "no power");
    probe.xfer(1'b0, 1'b0, `DP_ADDR_CTRL, 32'h50000000, ack, rdat);
    cmp({31'h0, power_up_request}, 32'h1, "power up");
    probe.xfer(1'b0, 1'b1, `DP_ADDR_CTRL, 32'h0, ack, rdat);
    cmp(rdat, 32'hF0000000, "power ack");
    probe.xfer(1'b0, 1'b1, `DP_ADDR_IDENT, 32'h0, ack, rdat);
    cmp(rdat, `DP_IDENT_WORD, "port ident");
    $display("power test done");
    rd(`CAP_OFS_PROTECT_STATUS, 32'h0, "protected");
    wr(`CAP_OFS_SOFT_RESET, 32'h1);
    cmp({31'h0, soft_reset}, 32'h1, "reset held");
    rd(`CAP_OFS_SOFT_RESET, 32'h1, "reset read");
    probe.flip_par = 1'b1;
    wr(`CAP_OFS_SOFT_RESET, 32'h0);
    probe.flip_par = 1'b0;
    cmp({31'h0, soft_reset}, 32'h1, "bad parity");
    wr(`CAP_OFS_SOFT_RESET, 32'h0);
    cmp({31'h0, soft_reset}, 32'h0, "reset free");
    $display("reset test done");
    rd(`CAP_OFS_ERASE_STATUS, 32'h0, "erase ready");
    wr(`CAP_OFS_MASS_ERASE, 32'h0);
    cmp(starts, 32'h0, "erase zero");
    wr(`CAP_OFS_MASS_ERASE, 32'h1);
    cmp({30'h0, starts == 1, erase_busy}, 32'h3, "erase on");
    rd(`CAP_OFS_ERASE_STATUS, 32'h1, "erase busy");
    wr(`CAP_OFS_MASS_ERASE, 32'h1);
    cmp(starts, 32'h1, "erase ignored");
    @(negedge clk_sys) erase_done = 1'b1;
    port_protection = 1'b0;
    @(negedge clk_sys) erase_done = 1'b0;
    rd(`CAP_OFS_ERASE_STATUS, 32'h0, "erase end");
    rd(`CAP_OFS_PROTECT_STATUS, 32'h1, "unprotected");
    $display("erase test done");
    rd(`CAP_OFS_IDENT, {`IDENT_REVISION, `IDENT_MAKER_BANK, `IDENT_MAKER_CODE, `IDENT_CLASS_NONE, 5'h00,
      `IDENT_PORT_ID}, "ident");
    probe.xfer(1'b0, 1'b0, `DP_ADDR_CTRL, 32'h0, ack, rdat);
    cmp({31'h0, power_up_request}, 32'h0, "power down");
    cmp({31'h0, probe.par_bad}, 32'h0, "read parity");
    $display("ident test done");
    stop_test;
  end
endmodule // testbench
